// >>> verilog/isclk_pkg.sv
// Purpose: Shared constants and types of the highway clock generator.
// Assumes: System clock of 10 MHz; oscillator modelled as a phase accumulator.
// Notes: All counts except RST_FRAMES, MIN_PHASE_NS and the channel shifts derive from the frequencies below.
package isclk_pkg;
    localparam int CLK_KHZ = 10000;
    localparam int OSC_KHZ = 7680;
    localparam int DCL_KHZ = 1536;
    localparam int FSC_KHZ = 8;
    localparam int DCL_MIN_KHZ = 512;
    localparam int DCL_DIV = OSC_KHZ / DCL_KHZ;
    localparam int DCL_HIGH = (DCL_DIV + 1) / 2;
    localparam int FRAME_DCL = DCL_KHZ / FSC_KHZ;
    localparam int FSC_HIGH = FRAME_DCL / 2;
    localparam int PRESENT_CYC = 2 * (CLK_KHZ / DCL_MIN_KHZ);
    localparam int MIN_PHASE_NS = 130;
    localparam int CLK_PERIOD_NS = 1000000 / CLK_KHZ;
    localparam int MIN_PHASE_CYC = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_FRAMES = 4;
    localparam int CH_SHIFT_DOUBLE = 6;
    localparam int CH_SHIFT_SINGLE = 5;
    localparam logic [2:0] MODE_RST = 3'h0;

    typedef enum logic [2:0] {
        MODE_TE,
        MODE_LTT,
        MODE_LTS,
        MODE_NT,
        MODE_INTNT
    } isclk_mode_t;
endpackage

// >>> verilog/isclk_hw_if.sv
// Purpose: Carries one set of highway clocks between the clock modules.
// Assumes: All members are levels or pulses in the clk_in domain.
// Notes: The source drives, the top module reads.
`timescale 1ns/10ps
interface isclk_hw_if;
    logic highway_data_clock;
    logic dcl_rise;
    logic highway_bit_clock;
    logic frame_sync_clock;
    logic fsc_rise;
    logic present;
    modport src (output highway_data_clock, dcl_rise, highway_bit_clock, frame_sync_clock, fsc_rise, present);
    modport dst (input highway_data_clock, dcl_rise, highway_bit_clock, frame_sync_clock, fsc_rise, present);
endinterface

// >>> verilog/isclk_receive_phase_loop.sv
// Purpose: Oscillator model and receive phase loop making line-locked clocks.
// Assumes: rx_ref_in is an asynchronous pin; frame_synced_in is on clk_in.
// Notes: One oscillator tick equals CLK_KHZ units of the accumulator.
`timescale 1ns/10ps
module isclk_receive_phase_loop (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic rx_ref_in,
    input wire logic frame_synced_in,
    output logic osc_level_out,
    isclk_hw_if.src loc
);
    localparam logic [14:0] STEP = 15'(isclk_pkg::OSC_KHZ);
    localparam logic [14:0] MODV = 15'(isclk_pkg::CLK_KHZ);
    localparam logic [14:0] HALF = 15'(isclk_pkg::CLK_KHZ / 2);
    localparam logic [2:0] LAST = 3'(isclk_pkg::DCL_DIV - 1);
    localparam logic [7:0] FLAST = 8'(isclk_pkg::FRAME_DCL - 1);
    logic [14:0] acc;
    logic [14:0] sum;
    logic osc_tick;
    logic [2:0] ph;
    logic [2:0] ph_last;
    logic [7:0] frame;
    logic [2:0] ref_sync;
    logic ref_fall;
    logic synced_d;
    logic highway_bit_clock;
    logic wrap;
    logic fsc_rise;

    assign sum = acc + STEP;
    assign osc_tick = sum >= MODV;
    assign ref_fall = ref_sync[2:1] == 2'h2;
    assign wrap = osc_tick && ph >= ph_last;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ref_sync <= 3'h0;
            synced_d <= 1'h0;
        end else begin
            ref_sync <= {ref_sync[1:0], rx_ref_in};
            synced_d <= frame_synced_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            acc <= 15'h0;
        end else if (ref_fall && (ph == 3'h1) && sum < MODV && sum >= HALF) begin
            acc <= sum - HALF;
        end else if (ref_fall && (ph == LAST) && sum < HALF) begin
            acc <= sum + HALF;
        end else begin
            acc <= osc_tick ? sum - MODV : sum;
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ph <= 3'h0;
            ph_last <= LAST;
        end else if (ref_fall && !frame_synced_in && ph > 3'h1 && ph < LAST) begin
            ph <= 3'h0;
            ph_last <= LAST;
        end else begin
            if (wrap) begin
                ph <= 3'h0;
                ph_last <= LAST;
            end else if (osc_tick) begin
                ph <= ph + 3'h1;
            end
            if (ref_fall && ph == 3'h2) begin
                ph_last <= LAST + 3'h1;
            end else if (ref_fall && ph == 3'h3) begin
                ph_last <= LAST - 3'h1;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            frame <= 8'h0;
            highway_bit_clock <= 1'h0;
            fsc_rise <= 1'h0;
        end else begin
            fsc_rise <= wrap && frame == FLAST;
            if (frame_synced_in && !synced_d) begin
                frame <= 8'h0;
            end else if (wrap) begin
                frame <= frame == FLAST ? 8'h0 : frame + 8'h1;
            end
            if (wrap) begin
                highway_bit_clock <= !highway_bit_clock;
            end
        end
    end
    assign loc.highway_data_clock = ph < 3'(isclk_pkg::DCL_HIGH);
    assign loc.dcl_rise = wrap;
    assign loc.highway_bit_clock = highway_bit_clock;
    assign loc.frame_sync_clock = frame < 8'(isclk_pkg::FSC_HIGH);
    assign loc.fsc_rise = fsc_rise;
    assign loc.present = 1'h1;
    assign osc_level_out = acc < HALF;

    property p_jitter_bound;
        @(posedge clk_in) disable iff (srst_in)
        ph_last >= LAST - 3'h1 && ph_last <= LAST + 3'h1;
    endproperty
    a_jitter_bound: assert property (p_jitter_bound) else $error("cycle correction too large");
    property p_realign;
        @(posedge clk_in) disable iff (srst_in)
        (frame_synced_in && !synced_d) |=> frame == 8'h0;
    endproperty
    a_realign: assert property (p_realign) else $error("frame not realigned");
endmodule

// >>> verilog/isclk_hwmon.sv
// Purpose: Samples highway clocks driven by the other party.
// Assumes: Pins are asynchronous to clk_in.
// Notes: The bit clock is the data clock divided by two.
`timescale 1ns/10ps
module isclk_hwmon (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic dcl_pin_in,
    input wire logic fsc_pin_in,
    isclk_hw_if.src ext
);
    localparam logic [6:0] TMO = 7'(isclk_pkg::PRESENT_CYC);
    logic [2:0] dcl_s;
    logic [2:0] fsc_s;
    logic highway_bit_clock;
    logic [6:0] idle;
    logic rise;

    assign rise = dcl_s[2:1] == 2'h1;
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dcl_s <= 3'h0;
            fsc_s <= 3'h0;
            idle <= TMO;
        end else begin
            dcl_s <= {dcl_s[1:0], dcl_pin_in};
            fsc_s <= {fsc_s[1:0], fsc_pin_in};
            idle <= rise ? 7'h0 : (idle < TMO ? idle + 7'h1 : idle);
        end
    end
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            highway_bit_clock <= 1'h0;
        end else if (rise) begin
            highway_bit_clock <= (fsc_s[2:1] == 2'h1) ? 1'h1 : !highway_bit_clock;
        end
    end
    assign ext.highway_data_clock = dcl_s[2];
    assign ext.dcl_rise = rise;
    assign ext.highway_bit_clock = highway_bit_clock;
    assign ext.frame_sync_clock = fsc_s[2];
    assign ext.fsc_rise = fsc_s[2:1] == 2'h1;
    assign ext.present = idle < TMO;

    property p_bcl_on_edge;
        @(posedge clk_in) disable iff (srst_in)
        $changed(highway_bit_clock) |-> $past(rise);
    endproperty
    a_bcl_on_edge: assert property (p_bcl_on_edge) else $error("bit clock moved off edge");
endmodule

// >>> verilog/isclk_top.sv
// Purpose: Highway clock generation, mode selection and layer-1 control routing.
// Assumes: Control bits come from same-clock logic; pins are synchronised here.
// Notes: Two-way clock pins appear as output, output enable and input.
`timescale 1ns/10ps
module isclk_top #(
    parameter int RST_FRAMES = isclk_pkg::RST_FRAMES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic mode_select_0_in,
    input wire logic mode_select_1_in,
    input wire logic mode_override_in,
    input wire logic [2:0] transceiver_mode_field_in,
    input wire logic transceiver_disable_in,
    input wire logic data_clock_rate_select_in,
    input wire logic aux_clock_function_select_in,
    input wire logic aux_clock_source_select_in,
    input wire logic layer1_software_control_in,
    input wire logic [3:0] layer1_command_reg_in,
    input wire logic [3:0] sm_command_in,
    input wire logic [3:0] l1_indication_in,
    input wire logic clock_stop_in_powerdown_in,
    input wire logic powerdown_in,
    input wire logic rx_ref_in,
    input wire logic frame_synced_in,
    input wire logic frame_sync_clock_in,
    input wire logic highway_data_clock_in,
    input wire logic cmd_reset_req_in,
    input wire logic external_awake_pin_in,
    input wire logic watchdog_req_in,
    output logic frame_sync_clock_out,
    output logic frame_sync_clock_oe_out,
    output logic highway_data_clock_out,
    output logic highway_data_clock_oe_out,
    output logic highway_bit_clock_out,
    output logic aux_divided_clock_pin_out,
    output logic aux_divided_clock_pin_oe_out,
    output logic buffered_osc_output_out,
    output logic data_line_hold_high_out,
    output logic [3:0] channel_count_out,
    output isclk_pkg::isclk_mode_t mode_out,
    output logic lts_machine_select_out,
    output logic sm_enable_out,
    output logic [3:0] layer1_cmd_out,
    output logic [3:0] layer1_status_reg_out,
    output logic reset_pulse_out
);
    isclk_hw_if loc ();
    isclk_hw_if ext ();
    logic osc_level;
    logic [1:0] ms0_s;
    logic [1:0] ms1_s;
    logic [2:0] eaw_s;
    isclk_pkg::isclk_mode_t strap_mode;
    isclk_pkg::isclk_mode_t next_mode;
    logic local_drive;
    logic stop;
    logic sel_fsc;
    logic sel_fsc_rise;
    logic sel_dcl_rise;
    logic sel_bcl;
    logic hw_present;
    logic reset_req;
    logic [9:0] dcl_count;
    logic [3:0] rst_left;

    // Decodes a three-bit mode word into an operating mode.
    function automatic isclk_pkg::isclk_mode_t decode_mode(input logic [2:0] f);
        isclk_pkg::isclk_mode_t m;
        if (f[2] && f[1]) begin
            m = isclk_pkg::MODE_INTNT;
        end else if (f[1] && !f[0]) begin
            m = isclk_pkg::MODE_NT;
        end else if (!f[0]) begin
            m = isclk_pkg::MODE_TE;
        end else if (!f[1]) begin
            m = isclk_pkg::MODE_LTT;
        end else begin
            m = isclk_pkg::MODE_LTS;
        end
        return m;
    endfunction

    isclk_receive_phase_loop u_receive_phase_loop (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .rx_ref_in(rx_ref_in),
        .frame_synced_in(frame_synced_in),
        .osc_level_out(osc_level),
        .loc(loc)
    );

    isclk_hwmon u_hwmon (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .dcl_pin_in(highway_data_clock_in),
        .fsc_pin_in(frame_sync_clock_in),
        .ext(ext)
    );

    // Strap synchronisers keep running in reset, so the strap is valid before release.
    always_ff @(posedge clk_in) begin
        ms0_s <= {ms0_s[0], mode_select_0_in};
        ms1_s <= {ms1_s[0], mode_select_1_in};
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            eaw_s <= 3'h0;
        end else begin
            eaw_s <= {eaw_s[1:0], external_awake_pin_in};
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            strap_mode <= decode_mode({1'h0, ms1_s[1] & ms0_s[1], ms0_s[1]});
        end
    end

    always_comb begin
        if (mode_override_in) begin
            next_mode = decode_mode(transceiver_mode_field_in);
        end else begin
            next_mode = strap_mode;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_out <= isclk_pkg::isclk_mode_t'(isclk_pkg::MODE_RST);
            lts_machine_select_out <= 1'h0;
        end else begin
            mode_out <= next_mode;
            lts_machine_select_out <= (next_mode == isclk_pkg::MODE_INTNT)
                && mode_override_in && transceiver_mode_field_in[0];
        end
    end

    assign local_drive = (mode_out == isclk_pkg::MODE_TE) && !transceiver_disable_in;
    assign stop = powerdown_in && clock_stop_in_powerdown_in;
    assign sel_fsc = local_drive ? loc.frame_sync_clock : ext.frame_sync_clock;
    assign sel_fsc_rise = local_drive ? loc.fsc_rise : ext.fsc_rise;
    assign sel_dcl_rise = local_drive ? loc.dcl_rise : ext.dcl_rise;
    assign hw_present = local_drive ? !stop : ext.present;

    always_comb begin
        if (local_drive) begin
            sel_bcl = loc.highway_bit_clock;
        end else if (mode_out == isclk_pkg::MODE_LTT) begin
            sel_bcl = loc.highway_data_clock;
        end else if (mode_out == isclk_pkg::MODE_TE && data_clock_rate_select_in) begin
            sel_bcl = ext.highway_data_clock;
        end else begin
            sel_bcl = ext.highway_bit_clock;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            frame_sync_clock_out <= 1'h0;
            frame_sync_clock_oe_out <= 1'h0;
            highway_data_clock_out <= 1'h0;
            highway_data_clock_oe_out <= 1'h0;
            highway_bit_clock_out <= 1'h0;
            data_line_hold_high_out <= 1'h0;
        end else begin
            frame_sync_clock_out <= local_drive && !stop && loc.frame_sync_clock;
            frame_sync_clock_oe_out <= local_drive;
            highway_data_clock_out <= local_drive && !stop && loc.highway_data_clock;
            highway_data_clock_oe_out <= local_drive;
            highway_bit_clock_out <= !stop && sel_bcl;
            data_line_hold_high_out <= stop;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            aux_divided_clock_pin_out <= 1'h0;
            aux_divided_clock_pin_oe_out <= 1'h0;
        end else begin
            aux_divided_clock_pin_oe_out <= aux_clock_function_select_in;
            aux_divided_clock_pin_out <= aux_clock_function_select_in && hw_present
                && (aux_clock_source_select_in ? sel_bcl : sel_fsc);
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            buffered_osc_output_out <= 1'h0;
        end else begin
            buffered_osc_output_out <= !powerdown_in && osc_level;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            dcl_count <= 10'h0;
            channel_count_out <= 4'h0;
        end else if (sel_fsc_rise) begin
            dcl_count <= 10'(sel_dcl_rise);
            if (!local_drive && data_clock_rate_select_in) begin
                channel_count_out <= 4'(dcl_count >> isclk_pkg::CH_SHIFT_SINGLE);
            end else begin
                channel_count_out <= 4'(dcl_count >> isclk_pkg::CH_SHIFT_DOUBLE);
            end
        end else if (sel_dcl_rise && dcl_count != 10'h3ff) begin
            dcl_count <= dcl_count + 10'h1;
        end
    end

    assign reset_req = cmd_reset_req_in || watchdog_req_in || (eaw_s[2:1] == 2'h1);
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rst_left <= 4'h0;
            reset_pulse_out <= 1'h0;
        end else begin
            if (reset_req) begin
                rst_left <= 4'(RST_FRAMES);
            end else if (sel_fsc_rise && rst_left != 4'h0) begin
                rst_left <= rst_left - 4'h1;
            end
            reset_pulse_out <= reset_req || rst_left != 4'h0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            sm_enable_out <= 1'h1;
            layer1_cmd_out <= 4'h0;
            layer1_status_reg_out <= 4'h0;
        end else begin
            sm_enable_out <= !layer1_software_control_in;
            layer1_cmd_out <= layer1_software_control_in ? layer1_command_reg_in
                : sm_command_in;
            layer1_status_reg_out <= l1_indication_in;
        end
    end

    property p_aux_off;
        @(posedge clk_in) disable iff (srst_in)
        !aux_clock_function_select_in |=> !aux_divided_clock_pin_out && !aux_divided_clock_pin_oe_out;
    endproperty
    a_aux_off: assert property (p_aux_off) else $error("aux pin active while disabled");
    property p_aux_present;
        @(posedge clk_in) disable iff (srst_in)
        aux_divided_clock_pin_out |-> $past(hw_present) && $past(aux_clock_function_select_in);
    endproperty
    a_aux_present: assert property (p_aux_present) else $error("aux clock without highway clocks");
    property p_osc_pd;
        @(posedge clk_in) disable iff (srst_in)
        powerdown_in |=> !buffered_osc_output_out;
    endproperty
    a_osc_pd: assert property (p_osc_pd) else $error("oscillator copy not low");
    property p_clock_stop;
        @(posedge clk_in) disable iff (srst_in)
        stop |=> data_line_hold_high_out && !highway_bit_clock_out && !highway_data_clock_out;
    endproperty
    a_clock_stop: assert property (p_clock_stop) else $error("clocks not stopped");
    property p_reset_width;
        @(posedge clk_in) disable iff (srst_in)
        reset_req |=> reset_pulse_out [*2];
    endproperty
    a_reset_width: assert property (p_reset_width) else $error("reset pulse too short");
    property p_intnt;
        @(posedge clk_in) disable iff (srst_in)
        (mode_override_in && transceiver_mode_field_in == 3'h6) |=>
            mode_out == isclk_pkg::MODE_INTNT && !lts_machine_select_out;
    endproperty
    a_intnt: assert property (p_intnt) else $error("intelligent NT mode wrong");
    property p_sw_cmd;
        @(posedge clk_in) disable iff (srst_in)
        layer1_software_control_in |=> layer1_cmd_out == $past(layer1_command_reg_in) && !sm_enable_out;
    endproperty
    a_sw_cmd: assert property (p_sw_cmd) else $error("software command not routed");
    property p_drive_te;
        @(posedge clk_in) disable iff (srst_in)
        frame_sync_clock_oe_out |-> $past(mode_out) == isclk_pkg::MODE_TE && !$past(transceiver_disable_in);
    endproperty
    a_drive_te: assert property (p_drive_te) else $error("frame sync driven outside TE");
endmodule

// >>> testbench/isclk_partner.sv
// Purpose: Layer-2 side source of the highway data and frame clocks.
// Assumes: Both clocks stand low while the source is disabled.
// Notes: Frame length is counted in data clock cycles.
`timescale 1ns/10ps
module isclk_partner #(
    parameter int HALF_NS = 400
) (
    input wire logic en_in,
    input wire logic [9:0] frame_len_in,
    output logic dcl_out,
    output logic fsc_out
);
    int n;
    initial begin
        dcl_out = 1'h0;
        fsc_out = 1'h0;
        n = 0;
        forever begin
            #(HALF_NS);
            dcl_out = en_in & ~dcl_out;
            fsc_out = en_in & (n < 2);
            if (!en_in) begin
                n = 0;
            end else if (dcl_out) begin
                n = (n + 1 >= int'(frame_len_in)) ? 0 : n + 1;
            end
        end
    end
endmodule

// >>> testbench/tb.sv
// Purpose: Self-checking bench of the highway clock generator.
// Assumes: Design assertions sit in the design files.
// Notes: Expected counts come from the frame and clock rates.
`timescale 1ns/10ps
module tb;
    localparam int RF = 2;
    logic clk_in, srst_in, ms0, ms1, ovr, dis, rate, afs, asrc, sw, cs, pd, rxr, fsy, pen;
    logic crq, external_awake_pin, wdq, fo, foe, dco, doe, bo, ao, aoe, oo, hh, lsel, sme, rp, pdcl, pfsc;
    logic [2:0] fld;
    logic [3:0] cmd, smc, ind, ch, l1c, l1s;
    logic [9:0] fl;
    logic [5:0] cur, pv;
    isclk_pkg::isclk_mode_t md, em;
    int err_count, tests_run, rc;
    int c[6], s[6];
    wire logic fw = foe ? fo : pfsc;
    wire logic dw = doe ? dco : pdcl;
    isclk_top #(.RST_FRAMES(RF)) isclk_top_inst (.clk_in(clk_in), .srst_in(srst_in),
        .mode_select_0_in(ms0), .mode_select_1_in(ms1), .mode_override_in(ovr),
        .transceiver_mode_field_in(fld), .transceiver_disable_in(dis),
        .data_clock_rate_select_in(rate), .aux_clock_function_select_in(afs),
        .aux_clock_source_select_in(asrc), .layer1_software_control_in(sw),
        .layer1_command_reg_in(cmd), .sm_command_in(smc), .l1_indication_in(ind),
        .clock_stop_in_powerdown_in(cs), .powerdown_in(pd), .rx_ref_in(rxr),
        .frame_synced_in(fsy), .frame_sync_clock_in(fw), .highway_data_clock_in(dw),
        .cmd_reset_req_in(crq), .external_awake_pin_in(external_awake_pin), .watchdog_req_in(wdq),
        .frame_sync_clock_out(fo), .frame_sync_clock_oe_out(foe), .highway_data_clock_out(dco),
        .highway_data_clock_oe_out(doe), .highway_bit_clock_out(bo),
        .aux_divided_clock_pin_out(ao), .aux_divided_clock_pin_oe_out(aoe),
        .buffered_osc_output_out(oo), .data_line_hold_high_out(hh), .channel_count_out(ch),
        .mode_out(md), .lts_machine_select_out(lsel), .sm_enable_out(sme),
        .layer1_cmd_out(l1c), .layer1_status_reg_out(l1s), .reset_pulse_out(rp));
    isclk_partner isclk_partner_inst (.en_in(pen), .frame_len_in(fl), .dcl_out(pdcl),
        .fsc_out(pfsc));
    assign cur = {1'h1, oo, ao, bo, dw, fw};
    // Rising edge counters: frame, data, bit, aux, oscillator, cycles.
    always @(posedge clk_in) begin
        pv <= cur;
        for (int i = 0; i < 5; i++) c[i] <= c[i] + int'(cur[i] & ~pv[i]);
        c[5] <= c[5] + 1;
    end
    // Line reference falls every eight nominal data clock periods, 1250/24 cycles.
    always @(negedge clk_in) begin
        rc <= (rc + 24 >= 625) ? rc - 601 : rc + 24;
        if (rc + 24 >= 625) rxr <= ~rxr;
    end
    function automatic int d(input int i);
        return c[i] - s[i];
    endfunction
    function automatic isclk_pkg::isclk_mode_t exp_mode(input logic [2:0] f);
        if (f[2:1] == 2'h3) return isclk_pkg::MODE_INTNT;
        if (f == 3'h2) return isclk_pkg::MODE_NT;
        if (!f[0]) return isclk_pkg::MODE_TE;
        return f[1] ? isclk_pkg::MODE_LTS : isclk_pkg::MODE_LTT;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s exp %0h got %0h", nm, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_in);
    endtask
    task automatic rst();
        srst_in = 1'h1;
        tick(8);
        chk("rst_mode", 32'(md), 0);
        srst_in = 1'h0;
        tick(3);
    endtask
    task automatic frame();
        for (int k = 0; k < 2; k++) begin
            s = c;
            for (int i = 0; i < 6000 && d(0) == 0; i++) tick(1);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        clk_in = 1'h0;
        forever #50 clk_in = ~clk_in;
    end
    initial begin
        repeat (90000) @(posedge clk_in);
        err_count++;
        final_report();
    end
    initial begin
        {srst_in, ms0, ms1, ovr, dis, rate, afs, asrc, sw, cs, pd, rxr, fsy, pen} = '0;
        {crq, external_awake_pin, wdq, fld, cmd, smc, ind, rc, err_count, tests_run} = '0;
        fl = 10'h0c0;
        void'($urandom(32'h0000_f99c));
        for (int i = 0; i < 4; i++) begin
            {ms1, ms0} = 2'(i);
            rst();
            em = exp_mode({1'h0, ms1 & ms0, ms0});
            chk("strap_mode", 32'(md), 32'(em));
            chk("fsc_oe", 32'(foe), 32'(em == isclk_pkg::MODE_TE));
            chk("dcl_oe", 32'(doe), 32'(em == isclk_pkg::MODE_TE));
        end
        {ms1, ms0} = 2'h0;
        rst();
        fsy = 1'h1;
        afs = 1'h1;
        frame();
        frame();
        chk("dcl_frame", d(1), 192);
        chk("bcl_frame", d(2), 96);
        chk("frame_len", 32'(d(5) inside {[1249:1251]}), 1);
        chk("aux_fsc", d(3), 1);
        chk("aux_oe", 32'(aoe), 1);
        chk("chan", 32'(ch), 3);
        chk("osc_runs", 32'(d(4) > 0), 1);
        asrc = 1'h1;
        frame();
        frame();
        chk("aux_bcl", d(3), 96);
        afs = 1'h0;
        tick(2);
        s = c;
        tick(300);
        chk("aux_off", 32'(d(3) * 2 + int'(aoe)), 0);
        for (int k = 0; k < 2; k++) begin
            {pd, cs} = {1'h1, ~1'(k)};
            tick(20);
            s = c;
            tick(300);
            chk("osc_pd", d(4), 0);
            chk("dcl_pd", 32'(d(1) > 0), k);
            chk("hold", 32'({hh, (dco | bo) & (k == 0)}), k ? 0 : 2);
        end
        pd = 1'h0;
        for (int k = 0; k < 3; k++) begin
            {wdq, external_awake_pin, crq} = 3'(1 << k);
            tick(2);
            {wdq, external_awake_pin, crq} = 3'h0;
            for (int i = 0; i < 10 && rp !== 1'h1; i++) tick(1);
            s = c;
            for (int i = 0; i < 9000 && rp === 1'h1; i++) tick(1);
            chk("rst_frames", d(0), RF);
        end
        ovr = 1'h1;
        for (int f = 0; f < 8; f++) begin
            fld = 3'(f);
            tick(2);
            if (f != 5) chk("mode", 32'(md), 32'(exp_mode(fld)));
            chk("lts_sel", 32'(lsel), 32'(f == 7));
        end
        ovr = 1'h0;
        for (int k = 0; k < 8; k++) begin
            {sw, cmd, smc, ind} = 13'($urandom);
            tick(2);
            chk("l1_cmd", {sme, l1c, l1s}, {~sw, sw ? cmd : smc, ind});
        end
        dis = 1'h1;
        afs = 1'h1;
        tick(3);
        s = c;
        tick(500);
        chk("ext_oe", 32'({foe, doe}), 0);
        chk("aux_noclk", d(3), 0);
        pen = 1'h1;
        for (int k = 0; k < 3; k++) begin
            fl = (k == 0) ? 10'h0c0 : (k == 1) ? 10'h200 : 10'h100;
            rate = 1'(k == 2);
            frame();
            frame();
            frame();
            chk("ext_bcl", d(2), (k == 2) ? d(1) : d(1) / 2);
            chk("ext_aux", d(3), d(2));
            chk("ext_chan", 32'(ch), (k == 0) ? 3 : 8);
        end
        final_report();
    end
endmodule
